// ==== logic/pwsbm_regs.vh ====
// Behaviour
// - window corner and size from settings
// - plain output is size plus one, rounded up to even
// - fetch pairs, skip N drops N pairs
// - column skip 2x yields 16,17,20,21
// - skipped size is twice ceiling of pairs
// - independent row/column skip and bin
// - bin value counts combined neighbours
// - column sum mode instead of average
// - illegal column skip replaced by legal
// - skip omits samples, bin uses all
// - row-major ascending, mirror reverses order
// - mirror touches only the active window
// - reversed readout reverses colour order
// - mirrored row bins still combine ascending
`ifndef PWSBM_REGS_VH
`define PWSBM_REGS_VH

// ==========================================================
// register byte offsets
`define PWSBM_OFF_ROW_START 8'h00
`define PWSBM_OFF_COL_START 8'h04
`define PWSBM_OFF_ROW_SIZE  8'h08
`define PWSBM_OFF_COL_SIZE  8'h0C
`define PWSBM_OFF_ROW_MODE  8'h10
`define PWSBM_OFF_COL_MODE  8'h14
`define PWSBM_OFF_CTRL      8'h18
`define PWSBM_OFF_OUT_SIZE  8'h1C
`define PWSBM_OFF_STATUS    8'h20

// ==========================================================
// field positions
`define PWSBM_SKIP_LSB      0
`define PWSBM_SKIP_MSB      2
`define PWSBM_BIN_LSB       4
`define PWSBM_BIN_MSB       5
`define PWSBM_CTRL_RUN      0
`define PWSBM_CTRL_MIR_ROW  1
`define PWSBM_CTRL_MIR_COL  2
`define PWSBM_CTRL_COL_SUM  3
`define PWSBM_OUTW_LSB      0
`define PWSBM_OUTH_LSB      16
`define PWSBM_STAT_BUSY     0
`define PWSBM_STAT_FCNT_LSB 16

// ==========================================================
// reset values
`define PWSBM_RST_ROW_START 12'h036
`define PWSBM_RST_COL_START 12'h010
`define PWSBM_RST_ROW_SIZE  12'h797
`define PWSBM_RST_COL_SIZE  12'hA1F
`define PWSBM_RST_MODE      6'h00
`define PWSBM_RST_CTRL      4'h0

// ==========================================================
// legal skip limits
`define PWSBM_SKIP_MAX_B0   3'h6
`define PWSBM_SKIP_MAX_B1   3'h5
`define PWSBM_SKIP_B3       3'h3

// ==========================================================
// bus answers
`define PWSBM_RESP_OKAY     2'h0
`define PWSBM_RESP_SLVERR   2'h2

`endif

// ==== logic/pwsbm_size_calc.v ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// pairs and output length of one axis
module pwsbm_size_calc #(
   parameter AW = 12
) (
   input  wire [AW-1:0] size,
   input  wire [2:0]    skip,
   output wire [AW-1:0] nPairs,
   output wire [AW-1:0] outLen
);
   wire [AW:0] span;
   wire [AW:0] stride;
   wire [AW:0] quot;

   assign span   = {1'b0, size} + {{AW{1'b0}}, 1'b1};
   assign stride = {{(AW-3){1'b0}}, skip, 1'b0} + {{(AW-1){1'b0}}, 2'h2};
   assign quot   = (span + stride - {{AW{1'b0}}, 1'b1}) / stride;
   assign nPairs = quot[AW-1:0];
   // no skip gives size plus one, rounded up to even
   assign outLen = {quot[AW-2:0], 1'b0};
endmodule
`default_nettype wire

// ==== logic/pwsbm_axis_seq.v ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// address walker for one axis
module pwsbm_axis_seq #(
   parameter AW = 12
) (
   input  wire          sys_clk,
   input  wire          reset,
   input  wire          restart,
   input  wire          step,
   input  wire [AW-1:0] start,
   input  wire [AW-1:0] nPairs,
   input  wire [2:0]    skip,
   input  wire [1:0]    bin,
   input  wire          mirror,
   output wire [AW-1:0] addr,
   output wire          grpEnd,
   output wire          last
);
   reg  [AW-1:0] pair_q;
   reg           half_q;
   reg  [1:0]    sub_q;
   wire [AW-1:0] pairEff;
   wire          halfEff;
   wire [AW-1:0] stride;
   wire [2*AW-1:0] base;

   assign stride  = {{(AW-4){1'b0}}, skip, 1'b0} + {{(AW-2){1'b0}}, 2'h2};
   assign pairEff = mirror ? (nPairs - pair_q - {{(AW-1){1'b0}}, 1'b1}) : pair_q;
   assign halfEff = mirror ? ~half_q : half_q;
   // each kept pair then N skipped pairs
   assign base    = pairEff * stride;
   assign addr    = start + base[AW-1:0] + {{(AW-1){1'b0}}, halfEff}
                    + {{(AW-3){1'b0}}, sub_q, 1'b0};
   // group holds bin plus one members
   assign grpEnd  = (sub_q == bin);
   assign last    = grpEnd && half_q && (pair_q == nPairs - {{(AW-1){1'b0}}, 1'b1});

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pair_q <= {AW{1'b0}};
         half_q <= 1'b0;
         sub_q  <= 2'h0;
      end else if (restart) begin
         pair_q <= {AW{1'b0}};
         half_q <= 1'b0;
         sub_q  <= 2'h0;
      end else if (step) begin
         // every member of a bin is visited
         if (!grpEnd) begin
            sub_q <= sub_q + 2'h1;
         end else begin
            sub_q  <= 2'h0;
            half_q <= ~half_q;
            if (half_q) begin
               pair_q <= last ? {AW{1'b0}} : pair_q + {{(AW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== logic/pwsbm_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "pwsbm_regs.vh"
// ==========================================================
// readout window, skip, bin and mirror sequencer
module pwsbm_top (
   input  wire        sys_clk,
   input  wire        reset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [11:0] rowAddr_q,
   output reg  [11:0] colAddr_q,
   output reg         sampleActive_q,
   output reg         pixelDone_q,
   output reg         colSum_q,
   output reg         frameStart_q
);
   // ==========================================================
   // legal column skip for a bin setting
   function [2:0] fixSkip;
      input [2:0] skip;
      input [1:0] bin;
      begin
         case (bin)
            2'h0: fixSkip = (skip > `PWSBM_SKIP_MAX_B0) ? `PWSBM_SKIP_MAX_B0 : skip;
            2'h1, 2'h2: begin
               if (skip > `PWSBM_SKIP_MAX_B1) fixSkip = `PWSBM_SKIP_MAX_B1;
               else fixSkip = skip | 3'h1;
            end
            default: fixSkip = `PWSBM_SKIP_B3;
         endcase
      end
   endfunction

   // bin 2 is not a supported factor, it runs as bin 2x
   function [1:0] fixBin;
      input [1:0] bin;
      begin
         fixBin = (bin == 2'h2) ? 2'h1 : bin;
      end
   endfunction

   // ==========================================================
   // software registers
   reg  [11:0] rowStart_q;
   reg  [11:0] colStart_q;
   reg  [11:0] rowSize_q;
   reg  [11:0] colSize_q;
   reg  [5:0]  rowMode_q;
   reg  [5:0]  colMode_q;
   reg  [3:0]  ctrl_q;
   reg  [15:0] frameCnt_q;

   // frame shadows so writes land on frame boundaries
   reg  [11:0] shRowStart_q;
   reg  [11:0] shColStart_q;
   reg  [11:0] shRowPairs_q;
   reg  [11:0] shColPairs_q;
   reg  [2:0]  shRowSkip_q;
   reg  [2:0]  shColSkip_q;
   reg  [1:0]  shRowBin_q;
   reg  [1:0]  shColBin_q;
   reg         shMirRow_q;
   reg         shMirCol_q;

   reg  [7:0]  awAddr_q;
   reg         awHeld_q;
   reg  [31:0] wData_q;
   reg  [3:0]  wStrb_q;
   reg         wHeld_q;

   wire [2:0]  rowSkipEff;
   wire [2:0]  colSkipEff;
   wire [1:0]  rowBinEff;
   wire [1:0]  colBinEff;
   wire [11:0] rowPairs;
   wire [11:0] colPairs;
   wire [11:0] outW;
   wire [11:0] outH;

   assign rowBinEff  = fixBin(rowMode_q[`PWSBM_BIN_MSB:`PWSBM_BIN_LSB]);
   assign colBinEff  = fixBin(colMode_q[`PWSBM_BIN_MSB:`PWSBM_BIN_LSB]);
   assign rowSkipEff = fixSkip(rowMode_q[`PWSBM_SKIP_MSB:`PWSBM_SKIP_LSB], rowBinEff);
   assign colSkipEff = fixSkip(colMode_q[`PWSBM_SKIP_MSB:`PWSBM_SKIP_LSB], colBinEff);

   pwsbm_size_calc #(.AW(12)) uRowSize (
      .size   (rowSize_q),
      .skip   (rowSkipEff),
      .nPairs (rowPairs),
      .outLen (outH)
   );

   pwsbm_size_calc #(.AW(12)) uColSize (
      .size   (colSize_q),
      .skip   (colSkipEff),
      .nPairs (colPairs),
      .outLen (outW)
   );

   // ==========================================================
   // axi4-lite write path
   wire        wrFire;
   reg  [31:0] wrMerged;
   reg  [31:0] wrOld;
   reg         wrHit;
   integer     bi;

   assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;

   always @* begin
      wrHit = 1'b1;
      case (awAddr_q)
         `PWSBM_OFF_ROW_START: wrOld = {20'h00000, rowStart_q};
         `PWSBM_OFF_COL_START: wrOld = {20'h00000, colStart_q};
         `PWSBM_OFF_ROW_SIZE:  wrOld = {20'h00000, rowSize_q};
         `PWSBM_OFF_COL_SIZE:  wrOld = {20'h00000, colSize_q};
         `PWSBM_OFF_ROW_MODE:  wrOld = {26'h0000000, rowMode_q};
         `PWSBM_OFF_COL_MODE:  wrOld = {26'h0000000, colMode_q};
         `PWSBM_OFF_CTRL:      wrOld = {28'h0000000, ctrl_q};
         default: begin
            wrOld = 32'h00000000;
            wrHit = 1'b0;
         end
      endcase
      for (bi = 0; bi < 4; bi = bi + 1) begin
         wrMerged[bi*8 +: 8] = wStrb_q[bi] ? wData_q[bi*8 +: 8] : wrOld[bi*8 +: 8];
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PWSBM_RESP_OKAY;
         awAddr_q      <= 8'h00;
         awHeld_q      <= 1'b0;
         wData_q       <= 32'h00000000;
         wStrb_q       <= 4'h0;
         wHeld_q       <= 1'b0;
         rowStart_q    <= `PWSBM_RST_ROW_START;
         colStart_q    <= `PWSBM_RST_COL_START;
         rowSize_q     <= `PWSBM_RST_ROW_SIZE;
         colSize_q     <= `PWSBM_RST_COL_SIZE;
         rowMode_q     <= `PWSBM_RST_MODE;
         colMode_q     <= `PWSBM_RST_MODE;
         ctrl_q        <= `PWSBM_RST_CTRL;
      end else begin
         s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr;
            awHeld_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wHeld_q <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wrFire) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `PWSBM_RESP_OKAY : `PWSBM_RESP_SLVERR;
            case (awAddr_q)
               `PWSBM_OFF_ROW_START: rowStart_q <= wrMerged[11:0];
               `PWSBM_OFF_COL_START: colStart_q <= wrMerged[11:0];
               `PWSBM_OFF_ROW_SIZE:  rowSize_q  <= wrMerged[11:0];
               `PWSBM_OFF_COL_SIZE:  colSize_q  <= wrMerged[11:0];
               `PWSBM_OFF_ROW_MODE:  rowMode_q  <= wrMerged[5:0];
               `PWSBM_OFF_COL_MODE:  colMode_q  <= wrMerged[5:0];
               `PWSBM_OFF_CTRL:      ctrl_q     <= wrMerged[3:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // axi4-lite read path
   reg  [31:0] rdVal;
   reg         rdHit;

   always @* begin
      rdHit = 1'b1;
      case (s_axi_araddr)
         `PWSBM_OFF_ROW_START: rdVal = {20'h00000, rowStart_q};
         `PWSBM_OFF_COL_START: rdVal = {20'h00000, colStart_q};
         `PWSBM_OFF_ROW_SIZE:  rdVal = {20'h00000, rowSize_q};
         `PWSBM_OFF_COL_SIZE:  rdVal = {20'h00000, colSize_q};
         `PWSBM_OFF_ROW_MODE:  rdVal = {26'h0000000, rowMode_q};
         `PWSBM_OFF_COL_MODE:  rdVal = {26'h0000000, colMode_q};
         `PWSBM_OFF_CTRL:      rdVal = {28'h0000000, ctrl_q};
         `PWSBM_OFF_OUT_SIZE:  rdVal = {4'h0, outH, 4'h0, outW};
         `PWSBM_OFF_STATUS:    rdVal = {frameCnt_q, 15'h0000, sampleActive_q};
         default: begin
            rdVal = 32'h00000000;
            rdHit = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PWSBM_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdVal;
            s_axi_rresp  <= rdHit ? `PWSBM_RESP_OKAY : `PWSBM_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // frame scan
   localparam ST_IDLE = 2'b01;
   localparam ST_SCAN = 2'b10;

   reg  [1:0]  state_q;
   wire        frameLoad;
   wire        scanning;
   wire [11:0] rowNext;
   wire [11:0] colNext;
   wire        rowGrpEnd;
   wire        colGrpEnd;
   wire        rowLast;
   wire        colLast;

   assign frameLoad = (state_q == ST_IDLE) && ctrl_q[`PWSBM_CTRL_RUN];
   assign scanning  = (state_q == ST_SCAN);

   pwsbm_axis_seq #(.AW(12)) uRowSeq (
      .sys_clk (sys_clk),
      .reset   (reset),
      .restart (frameLoad),
      .step    (scanning && colLast),
      .start   (shRowStart_q),
      .nPairs  (shRowPairs_q),
      .skip    (shRowSkip_q),
      .bin     (shRowBin_q),
      .mirror  (shMirRow_q),
      .addr    (rowNext),
      .grpEnd  (rowGrpEnd),
      .last    (rowLast)
   );

   // column skip stride of 2*(skip+1) from start, four at skip 2x
   pwsbm_axis_seq #(.AW(12)) uColSeq (
      .sys_clk (sys_clk),
      .reset   (reset),
      .restart (frameLoad),
      .step    (scanning),
      .start   (shColStart_q),
      .nPairs  (shColPairs_q),
      .skip    (shColSkip_q),
      .bin     (shColBin_q),
      .mirror  (shMirCol_q),
      .addr    (colNext),
      .grpEnd  (colGrpEnd),
      .last    (colLast)
   );

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q        <= ST_IDLE;
         shRowStart_q   <= 12'h000;
         shColStart_q   <= 12'h000;
         shRowPairs_q   <= 12'h001;
         shColPairs_q   <= 12'h001;
         shRowSkip_q    <= 3'h0;
         shColSkip_q    <= 3'h0;
         shRowBin_q     <= 2'h0;
         shColBin_q     <= 2'h0;
         shMirRow_q     <= 1'b0;
         shMirCol_q     <= 1'b0;
         rowAddr_q      <= 12'h000;
         colAddr_q      <= 12'h000;
         sampleActive_q <= 1'b0;
         pixelDone_q    <= 1'b0;
         colSum_q       <= 1'b0;
         frameStart_q   <= 1'b0;
         frameCnt_q     <= 16'h0000;
      end else begin
         frameStart_q <= frameLoad;
         // sum or average flag for the column combiner
         colSum_q     <= ctrl_q[`PWSBM_CTRL_COL_SUM];
         case (state_q)
            ST_IDLE: begin
               sampleActive_q <= 1'b0;
               pixelDone_q    <= 1'b0;
               if (frameLoad) begin
                  state_q      <= ST_SCAN;
                  shRowStart_q <= rowStart_q;
                  shColStart_q <= colStart_q;
                  shRowPairs_q <= rowPairs;
                  shColPairs_q <= colPairs;
                  shRowSkip_q  <= rowSkipEff;
                  shColSkip_q  <= colSkipEff;
                  shRowBin_q   <= rowBinEff;
                  shColBin_q   <= colBinEff;
                  // mirror only steers the active walkers
                  shMirRow_q   <= ctrl_q[`PWSBM_CTRL_MIR_ROW];
                  shMirCol_q   <= ctrl_q[`PWSBM_CTRL_MIR_COL];
               end
            end
            ST_SCAN: begin
               // address pair and active flag each clock
               rowAddr_q      <= rowNext;
               colAddr_q      <= colNext;
               sampleActive_q <= 1'b1;
               pixelDone_q    <= rowGrpEnd && colGrpEnd;
               if (colLast && rowLast) begin
                  state_q    <= ST_IDLE;
                  frameCnt_q <= frameCnt_q + 16'h0001;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verification/pwsbm_array_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// array sampling circuits: records the addresses asked for
module pwsbm_array_model (
   input wire logic        sys_clk,
   input wire logic [11:0] rowAddr_q,
   input wire logic [11:0] colAddr_q,
   input wire logic        sampleActive_q,
   input wire logic        pixelDone_q,
   input wire logic        frameStart_q
);
   logic [11:0] rowSeen [0:15];
   logic [11:0] colSeen [0:15];
   int          nSeen;
   int          nGroups;

   always @(posedge sys_clk) begin
      if (frameStart_q) begin
         nSeen   <= 0;
         nGroups <= 0;
      end else if (sampleActive_q) begin
         if (nSeen < 16) begin
            rowSeen[nSeen] <= rowAddr_q;
            colSeen[nSeen] <= colAddr_q;
         end
         nSeen   <= nSeen + 1;
         nGroups <= nGroups + int'(pixelDone_q);
      end
   end
endmodule
`default_nettype wire

// ==== verification/pwsbm_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bus answer and sample stream checks
module pwsbm_checker (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sampleActive_q,
   input wire logic        pixelDone_q,
   input wire logic        frameStart_q
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_bWait;
      ##[1:2] s_axi_bvalid;
   endsequence
   sequence s_firstSample;
      ##[1:2] sampleActive_q;
   endsequence

   property p_wrAnswer;
      s_wrTaken |-> s_bWait;
   endproperty
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_bClear;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_rdAnswer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_rHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_arBlock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_errZero;
      s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
   endproperty
   property p_fsPulse;
      frameStart_q |=> !frameStart_q;
   endproperty
   property p_fsLead;
      frameStart_q |-> s_firstSample;
   endproperty
   property p_doneInFrame;
      pixelDone_q |-> sampleActive_q;
   endproperty

   a_wrAnswer: assert property (p_wrAnswer) else $error("write answer late");
   a_bHold: assert property (p_bHold) else $error("write answer dropped");
   a_bClear: assert property (p_bClear) else $error("write answer stuck");
   a_rdAnswer: assert property (p_rdAnswer) else $error("read answer late");
   a_rHold: assert property (p_rHold) else $error("read answer dropped");
   a_arBlock: assert property (p_arBlock) else $error("read taken while busy");
   a_errZero: assert property (p_errZero) else $error("error read not zero");
   a_fsPulse: assert property (p_fsPulse) else $error("frame start too long");
   a_fsLead: assert property (p_fsLead) else $error("no samples after start");
   a_doneInFrame: assert property (p_doneInFrame) else $error("group end idle");
endmodule

bind pwsbm_top pwsbm_checker pwsbm_checker_inst (.sys_clk, .reset, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .sampleActive_q, .pixelDone_q, .frameStart_q);
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pwsbm_regs.vh"
// ==========================================================
// sequencer bench
module tb;
   logic        sys_clk, reset;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] rowAddr_q, colAddr_q;
   logic        sampleActive_q, pixelDone_q, colSum_q, frameStart_q;
   int          nFail, comparisons;

   pwsbm_top pwsbm_top_inst (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rowAddr_q, .colAddr_q, .sampleActive_q, .pixelDone_q,
      .colSum_q, .frameStart_q);
   pwsbm_array_model pwsbm_array_model_inst (.sys_clk, .rowAddr_q, .colAddr_q,
      .sampleActive_q, .pixelDone_q, .frameStart_q);

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         nFail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit bd;
      bd = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!bd) begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            bd = 1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit rdn;
      rdn = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!rdn) begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            rdn = 1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask

   // output length of one axis under skip
   function automatic logic [15:0] osz(input int size, input int skip);
      int span;
      span = 2 * (skip + 1);
      return 16'(2 * ((size + span) / span));
   endfunction

   // window and modes; starts even, sizes odd, row start 12 or more
   task automatic setup(input int rs, cs, rz, cz, input logic [5:0] rm, cm);
      wr(`PWSBM_OFF_ROW_START, 32'(rs), rsp);
      wr(`PWSBM_OFF_COL_START, 32'(cs), rsp);
      wr(`PWSBM_OFF_ROW_SIZE, 32'(rz), rsp);
      wr(`PWSBM_OFF_COL_SIZE, 32'(cz), rsp);
      wr(`PWSBM_OFF_ROW_MODE, {26'h0, rm}, rsp);
      wr(`PWSBM_OFF_COL_MODE, {26'h0, cm}, rsp);
   endtask

   task automatic outSize(input logic [31:0] exp);
      logic [31:0] d;
      rd(`PWSBM_OFF_OUT_SIZE, d, rsp);
      chk("output size", exp, d);
   endtask

   // one frame: start, then clear run so it stops after this frame; a hang ends in the watchdog
   task automatic frame(input logic [3:0] ctl);
      wr(`PWSBM_OFF_CTRL, {28'h0, ctl | 4'h1}, rsp);
      wr(`PWSBM_OFF_CTRL, {28'h0, ctl}, rsp);
      while (!sampleActive_q) @(posedge sys_clk);
      while (sampleActive_q) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic t_reset;
      logic [31:0] d;
      logic [31:0] rv [4] = '{`PWSBM_RST_ROW_START, `PWSBM_RST_COL_START,
                              `PWSBM_RST_ROW_SIZE, `PWSBM_RST_COL_SIZE};
      for (int i = 0; i < 4; i++) begin
         rd(8'(i * 4), d, rsp);
         chk("reset value", rv[i], d);
      end
      outSize({osz(`PWSBM_RST_ROW_SIZE, 0), osz(`PWSBM_RST_COL_SIZE, 0)});
      rd(8'h40, d, rsp);
      chk("unmapped resp", 32'(`PWSBM_RESP_SLVERR), 32'(rsp));
      chk("unmapped data", 32'h0, d);
      $display("test reset done");
   endtask

   task automatic t_plain;
      setup(12, 16, 3, 7, 6'h00, 6'h00);
      outSize(32'h0004_0008);
      frame(4'h0);
      for (int k = 0; k < 8; k++) begin
         chk("column", 32'(16 + k), pwsbm_array_model_inst.colSeen[k]);
      end
      chk("first row", 32'd12, pwsbm_array_model_inst.rowSeen[0]);
      chk("second row", 32'd13, pwsbm_array_model_inst.rowSeen[8]);
      chk("samples", 32'd32, pwsbm_array_model_inst.nGroups);
      $display("test plain done");
   endtask

   task automatic t_skip;
      setup(12, 16, 3, 7, 6'h01, 6'h01);
      outSize({osz(3, 1), osz(7, 1)});
      frame(4'h0);
      for (int k = 0; k < 4; k++) begin
         chk("column", 32'(16 + k % 2 + 4 * (k / 2)), pwsbm_array_model_inst.colSeen[k]);
      end
      chk("skip row", 32'd13, pwsbm_array_model_inst.rowSeen[4]);
      chk("samples", 32'd8, pwsbm_array_model_inst.nGroups);
      $display("test skip done");
   endtask

   task automatic t_mirror;
      setup(12, 16, 3, 7, 6'h00, 6'h00);
      frame(4'h6);
      for (int k = 0; k < 8; k++) begin
         chk("column", 32'(23 - k), pwsbm_array_model_inst.colSeen[k]);
      end
      chk("first row", 32'd15, pwsbm_array_model_inst.rowSeen[0]);
      chk("second row", 32'd14, pwsbm_array_model_inst.rowSeen[8]);
      $display("test mirror done");
   endtask

   task automatic t_bin;
      setup(12, 16, 3, 15, 6'h00, 6'h30);
      outSize({osz(3, 0), osz(15, `PWSBM_SKIP_B3)});
      frame(4'h8);
      chk("groups", 32'd16, pwsbm_array_model_inst.nGroups);
      chk("sum mode", 32'd1, 32'(colSum_q));
      wr(`PWSBM_OFF_COL_MODE, 32'h27, rsp);
      outSize({osz(3, 0), osz(15, 5)});
      $display("test bin done");
   endtask

   task automatic t_rowbin;
      logic [31:0] d;
      setup(12, 16, 7, 7, 6'h11, 6'h00);
      outSize({osz(7, 1), osz(7, 0)});
      frame(4'h2);
      chk("sum mode", 32'd0, 32'(colSum_q));
      chk("first row", 32'd17, pwsbm_array_model_inst.rowSeen[0]);
      chk("bin partner", 32'd19, pwsbm_array_model_inst.rowSeen[8]);
      wr(`PWSBM_OFF_OUT_SIZE, 32'h0, rsp);
      chk("read-only resp", 32'(`PWSBM_RESP_SLVERR), 32'(rsp));
      outSize(32'h0004_0008);
      rd(`PWSBM_OFF_STATUS, d, rsp);
      chk("status", 32'h0005_0000, d);
      $display("test row bin done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, nFail);
      if (nFail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      nFail++;
      wrap_up();
   end

   initial begin
      nFail = 0;
      comparisons = 0;
      reset = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_plain();
      t_skip();
      t_mirror();
      t_bin();
      t_rowbin();
      wrap_up();
   end
endmodule
`default_nettype wire
